// File: logic/ipd_pkg.sv
// Shared constants for the input port loop control and status block
package ipd_pkg;
  localparam int          ADDR_W          = 7;
  localparam int          DATA_W          = 8;
  localparam int          XFER_BITS       = 16;
  // Register offsets
  localparam logic [6:0]  OFS_POWER       = 7'h01;
  localparam logic [6:0]  OFS_LOOP_CTRL   = 7'h0a;
  localparam logic [6:0]  OFS_LOOP_CFG    = 7'h0d;
  localparam logic [6:0]  OFS_LOOP_STAT   = 7'h0e;
  localparam logic [6:0]  OFS_DELAY_CELL  = 7'h5e;
  // Reset values
  localparam logic [7:0]  RST_POWER       = 8'h00;
  localparam logic [7:0]  RST_LOOP_CTRL   = 8'h00;
  localparam logic [7:0]  RST_LOOP_CFG    = 8'h00;
  localparam logic [7:0]  RST_DELAY_CELL  = 8'h00;
  // Field positions
  localparam int          PWR_MUTE_HI     = 7;
  localparam int          PWR_MUTE_LO     = 6;
  localparam int          CTRL_LOOP_EN    = 7;
  localparam int          CTRL_DCC_EN     = 6;
  localparam int          CTRL_OFS_SIGN   = 3;
  localparam int          CELL_LSB        = 0;
  localparam int          STAT_RUN        = 0;
  localparam int          STAT_CLK_OK     = 2;
  localparam int          STAT_WARN_LO    = 4;
  localparam int          STAT_WARN_HI    = 6;
  localparam int          STAT_LOCK       = 7;
  // Offset magnitude limits
  localparam logic [2:0]  OFS_MAG_EDGE    = 3'h6;
  localparam logic [2:0]  OFS_MAG_BAD     = 3'h7;
  // Timing counts
  localparam int          LOCK_DCI_CYCLES = 64;
  localparam int          CLK_TIMEOUT     = 16;
  localparam int          SPI_CMD_LAST    = 7;
  localparam int          SPI_DATA_LAST   = 15;
endpackage : ipd_pkg

// File: logic/ipd_link.sv
// Link-side logic on the forwarded data clock: lock tracking and DDR capture
module ipd_link
  import ipd_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_DCI_CYCLES,
  parameter int DW          = 16
)(
  input  wire logic          forwarded_data_clock,
  input  wire logic          rst,
  input  wire logic          loop_en,
  input  wire logic [DW-1:0] data_in,
  output logic               running,
  output logic               locked,
  output logic               beat_tgl,
  output logic [DW-1:0]      in_phase_data,
  output logic [DW-1:0]      quadrature_data
);
  localparam int CW = $clog2(LOCK_CYCLES + 1);

  logic          en_s1_reg;
  logic          en_s2_reg;
  logic [CW-1:0] lock_cnt_reg;
  logic [CW-1:0] lock_cnt_next;
  logic          lock_done;

  assign lock_done     = (lock_cnt_reg == CW'(LOCK_CYCLES - 1));
  assign lock_cnt_next = (!en_s2_reg) ? '0 :
                         (locked) ? lock_cnt_reg : lock_cnt_reg + CW'(1);

  always_ff @(posedge forwarded_data_clock or posedge rst)
  begin
    if (rst)
    begin
      en_s1_reg <= 1'b0;
      en_s2_reg <= 1'b0;
    end
    else
    begin
      en_s1_reg <= loop_en;
      en_s2_reg <= en_s1_reg;
    end
  end

  // Loop runs while enabled and acquires lock after a fixed count of edges
  always_ff @(posedge forwarded_data_clock or posedge rst)
  begin
    if (rst)
    begin
      lock_cnt_reg <= '0;
      running      <= 1'b0;
      locked       <= 1'b0;
    end
    else
    begin
      lock_cnt_reg <= lock_cnt_next;
      running      <= en_s2_reg;
      locked       <= en_s2_reg & (locked | lock_done);
    end
  end

  // Heartbeat relies on a free-toggling alternating clock pattern from the host
  always_ff @(posedge forwarded_data_clock or posedge rst)
  begin
    if (rst)
      beat_tgl <= 1'b0;
    else
      beat_tgl <= ~beat_tgl;
  end

  // In-phase word on the rising edge, quadrature word on the falling edge
  always_ff @(posedge forwarded_data_clock or posedge rst)
  begin
    if (rst)
      in_phase_data <= '0;
    else
      in_phase_data <= data_in;
  end

  always_ff @(negedge forwarded_data_clock or posedge rst)
  begin
    if (rst)
      quadrature_data <= '0;
    else
      quadrature_data <= data_in;
  end

  AST_LOCK_TIME: assert property (@(posedge forwarded_data_clock) disable iff (rst)
    $rose(locked) |-> $past(lock_cnt_reg) == CW'(LOCK_CYCLES - 1))
    else $error("lock rose before the lock count elapsed");
  AST_LOCK_DROP: assert property (@(posedge forwarded_data_clock) disable iff (rst)
    !en_s2_reg |=> !locked && !running)
    else $error("loop stayed active after disable");
  COV_LOCK: cover property (@(posedge forwarded_data_clock) disable iff (rst) $rose(locked));
endmodule : ipd_link

// File: logic/ipd_top.sv
// Serial register port, loop status and output mute for the input port loop
module ipd_top
  import ipd_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_DCI_CYCLES,
  parameter int TIMEOUT     = CLK_TIMEOUT,
  parameter int DW          = 16
)(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          spi_clk,
  input  wire logic          spi_cs_n,
  input  wire logic          sdio_in,
  output logic               sdio_out,
  output logic               sdio_oe,
  input  wire logic          forwarded_data_clock,
  input  wire logic [DW-1:0] data_in,
  output logic [DW-1:0]      in_phase_data,
  output logic [DW-1:0]      quadrature_data,
  output logic               dac_out_en,
  output logic [3:0]         phase_offset,
  output logic               dcc_en
);
  localparam int TW = $clog2(TIMEOUT + 1);

  logic       sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic       cs_s1_reg, cs_s2_reg;
  logic       din_s1_reg, din_s2_reg;
  logic       run_s1_reg, run_s2_reg;
  logic       lock_s1_reg, lock_s2_reg;
  logic       beat_s1_reg, beat_s2_reg, beat_s3_reg;
  logic       lnk_running, lnk_locked, lnk_beat;
  logic [7:0] power_reg, ctrl_reg, cfg_reg, cell_reg;
  logic [TW-1:0] present_cnt_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] shin_reg;
  logic [7:0] shout_reg;
  logic       rd_reg;
  logic [6:0] addr_reg;
  logic       rd_phase_reg;
  logic       out_reg;
  logic       sclk_rise, sclk_fall, cs_active;
  logic       cmd_done, wr_commit;
  logic [7:0] wr_data;
  logic [6:0] cmd_addr;
  logic       clk_present, running, locked;
  logic [2:0] ofs_mag;
  logic [2:0] warn;
  logic [7:0] status_byte;
  logic [7:0] rd_mux;

  ipd_link #(
    .LOCK_CYCLES (LOCK_CYCLES),
    .DW          (DW)
  ) u_link (
    .forwarded_data_clock (forwarded_data_clock),
    .rst                  (rst),
    .loop_en              (ctrl_reg[CTRL_LOOP_EN]),
    .data_in              (data_in),
    .running              (lnk_running),
    .locked               (lnk_locked),
    .beat_tgl             (lnk_beat),
    .in_phase_data        (in_phase_data),
    .quadrature_data      (quadrature_data)
  );

  // Synchronisers for pins and link-domain levels
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // Serial clock idles high, so a low reset value would fake a rising edge
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= 3'h7;
      {cs_s1_reg, cs_s2_reg}                  <= 2'h3;
      {din_s1_reg, din_s2_reg}                <= 2'h0;
      {run_s1_reg, run_s2_reg}                <= 2'h0;
      {lock_s1_reg, lock_s2_reg}              <= 2'h0;
      {beat_s1_reg, beat_s2_reg, beat_s3_reg} <= 3'h0;
    end
    else
    begin
      {sclk_s1_reg, sclk_s2_reg, sclk_s3_reg} <= {spi_clk, sclk_s1_reg, sclk_s2_reg};
      {cs_s1_reg, cs_s2_reg}                  <= {spi_cs_n, cs_s1_reg};
      {din_s1_reg, din_s2_reg}                <= {sdio_in, din_s1_reg};
      {run_s1_reg, run_s2_reg}                <= {lnk_running, run_s1_reg};
      {lock_s1_reg, lock_s2_reg}              <= {lnk_locked, lock_s1_reg};
      {beat_s1_reg, beat_s2_reg, beat_s3_reg} <= {lnk_beat, beat_s1_reg, beat_s2_reg};
    end
  end

  // Clock present while the link heartbeat keeps changing within the timeout
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      present_cnt_reg <= '0;
    else if (beat_s2_reg ^ beat_s3_reg)
      present_cnt_reg <= TW'(TIMEOUT);
    else if (present_cnt_reg != '0)
      present_cnt_reg <= present_cnt_reg - TW'(1);
  end

  assign clk_present = (present_cnt_reg != '0);
  // A stopped clock freezes the link flops, so status is gated by presence
  assign running     = run_s2_reg & clk_present;
  assign locked      = lock_s2_reg & clk_present;
  assign ofs_mag     = ctrl_reg[2:0];
  assign warn[0]     = running & cell_reg[CELL_LSB];
  assign warn[1]     = running & (ofs_mag == OFS_MAG_EDGE);
  assign warn[2]     = running & (ofs_mag == OFS_MAG_BAD);
  assign status_byte = {locked, warn, 1'b0, clk_present, 1'b0, running};

  // Serial port: R/W bit, 7 address bits, 8 data bits, MSB first
  assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  assign sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
  assign cs_active = ~cs_s2_reg;
  assign cmd_done  = cs_active & sclk_rise & (bit_cnt_reg == 5'(SPI_CMD_LAST));
  assign wr_commit = cs_active & sclk_rise & (bit_cnt_reg == 5'(SPI_DATA_LAST)) & ~rd_reg;
  assign wr_data   = {shin_reg[6:0], din_s2_reg};
  assign cmd_addr  = {shin_reg[5:0], din_s2_reg};
  assign rd_mux    = (cmd_addr == OFS_POWER)      ? power_reg :
                     (cmd_addr == OFS_LOOP_CTRL)  ? ctrl_reg :
                     (cmd_addr == OFS_LOOP_CFG)   ? cfg_reg :
                     (cmd_addr == OFS_LOOP_STAT)  ? status_byte :
                     (cmd_addr == OFS_DELAY_CELL) ? cell_reg : 8'h00;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_reg <= '0;
      shin_reg    <= '0;
      rd_reg      <= 1'b0;
      addr_reg    <= '0;
    end
    else if (!cs_active)
      bit_cnt_reg <= '0;
    else if (sclk_rise)
    begin
      bit_cnt_reg <= bit_cnt_reg + 5'(1);
      shin_reg    <= wr_data;
      if (bit_cnt_reg == 5'(SPI_CMD_LAST))
      begin
        rd_reg   <= shin_reg[6];
        addr_reg <= cmd_addr;
      end
    end
  end

  // Read data is frozen at command time, so a status read is a snapshot
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      shout_reg    <= '0;
      rd_phase_reg <= 1'b0;
      out_reg      <= 1'b0;
    end
    else if (!cs_active)
      rd_phase_reg <= 1'b0;
    else if (cmd_done && shin_reg[6])
    begin
      rd_phase_reg <= 1'b1;
      shout_reg    <= rd_mux;
    end
    else if (rd_phase_reg && sclk_fall)
    begin
      out_reg   <= shout_reg[7];
      shout_reg <= {shout_reg[6:0], 1'b0};
    end
  end

  assign sdio_out = out_reg;
  assign sdio_oe  = rd_phase_reg & cs_active;

  // Writes to the status offset match no register and are dropped
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      power_reg <= RST_POWER;
      ctrl_reg  <= RST_LOOP_CTRL;
      cfg_reg   <= RST_LOOP_CFG;
      cell_reg  <= RST_DELAY_CELL;
    end
    else if (wr_commit)
    begin
      if (addr_reg == OFS_POWER)
        power_reg <= wr_data;
      if (addr_reg == OFS_LOOP_CTRL)
        ctrl_reg <= wr_data;
      if (addr_reg == OFS_LOOP_CFG)
        cfg_reg <= wr_data;
      if (addr_reg == OFS_DELAY_CELL)
        cell_reg <= wr_data;
    end
  end

  // Mixed mute bits keep the previous output state
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      dac_out_en <= 1'b0;
    else if (power_reg[PWR_MUTE_HI] && power_reg[PWR_MUTE_LO])
      dac_out_en <= 1'b0;
    else if (!power_reg[PWR_MUTE_HI] && !power_reg[PWR_MUTE_LO])
      dac_out_en <= 1'b1;
  end

  assign phase_offset = ctrl_reg[3:0];
  assign dcc_en       = ctrl_reg[CTRL_DCC_EN];

  AST_LOCK_RUN: assert property (@(posedge ref_clk) disable iff (rst)
    status_byte[STAT_LOCK] |-> status_byte[STAT_RUN])
    else $error("locked shown without running");
  AST_PRESENT_DROP: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(clk_present) |-> $past(present_cnt_reg) == TW'(1))
    else $error("clock present dropped early");
  AST_WARN_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    !status_byte[STAT_RUN] |-> status_byte[STAT_WARN_HI:STAT_WARN_LO] == 3'h0)
    else $error("warning shown while loop idle");
  AST_SNAPSHOT: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_done && shin_reg[6] && cmd_addr == OFS_LOOP_STAT
    |=> shout_reg == $past(status_byte))
    else $error("status read not captured at read time");
  AST_MUTE: assert property (@(posedge ref_clk) disable iff (rst)
    power_reg[7:6] == 2'h3 |=> !dac_out_en)
    else $error("output enabled while muted");
  AST_UNMUTE: assert property (@(posedge ref_clk) disable iff (rst)
    power_reg[7:6] == 2'h0 |=> dac_out_en)
    else $error("output not enabled after unmute");
  AST_CTRL_WR: assert property (@(posedge ref_clk) disable iff (rst)
    wr_commit && addr_reg == OFS_LOOP_CTRL && wr_data == 8'hc0
    |=> ctrl_reg[CTRL_LOOP_EN] && dcc_en && phase_offset == 4'h0)
    else $error("enable write did not take effect");
  AST_NIBBLE: assert property (@(posedge ref_clk) disable iff (rst)
    locked && warn == 3'h0 |-> status_byte[7:4] == 4'h8)
    else $error("locked nibble not 1000b");
  AST_RO: assert property (@(posedge ref_clk) disable iff (rst)
    wr_commit && addr_reg == OFS_LOOP_STAT
    |=> $stable(power_reg) && $stable(ctrl_reg) && $stable(cfg_reg) && $stable(cell_reg))
    else $error("write to status changed a register");
  COV_LOCKED: cover property (@(posedge ref_clk) disable iff (rst) $rose(locked));
  COV_STAT_READ: cover property (@(posedge ref_clk) disable iff (rst)
    cmd_done && shin_reg[6] && cmd_addr == OFS_LOOP_STAT);
  COV_MUTE: cover property (@(posedge ref_clk) disable iff (rst) $fell(dac_out_en));
endmodule : ipd_top

// File: test/ipd_host_model.sv
// Host-side model driving the forwarded data clock and the double-rate data words
module ipd_host_model
(
  input  wire logic        run,
  input  wire logic [15:0] i_word,
  input  wire logic [15:0] q_word,
  output logic             forwarded_data_clock,
  output logic [15:0]      data_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // Phase offset keeps the link edges unrelated to ref_clk
  initial
  begin
    forwarded_data_clock = 1'b0;
    data_in = 16'h0000;
    #5.3;
    forever
    begin
      if (run)
      begin
        // Clock sent as one more lane toggling 0-1 from the same driver as data
        forwarded_data_clock = 1'b1;
        // Words change a quarter period after each edge, centring the sampling eye
        #3 data_in = q_word;
        #3 forwarded_data_clock = 1'b0;
        #3 data_in = i_word;
        #3;
      end
      else
      begin
        // Clock stands still between bursts; released data lines keep moving
        forwarded_data_clock = 1'b0;
        #6 data_in = ~data_in;
      end
    end
  end
endmodule : ipd_host_model

// File: test/ipd_top_tb_top.sv
// Self-checking bench for the input port loop control and status block
module ipd_top_tb_top
  import ipd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {string name; logic [7:0] val;} ipd_exp_t;

  logic        ref_clk, rst, spi_clk, spi_cs_n, tb_sdio, host_run;
  logic        sdio_out, sdio_oe, dac_out_en, dcc_en, fwd_clk;
  wire         sdio_in = sdio_oe ? sdio_out : tb_sdio;
  logic [3:0]  phase_offset;
  logic [15:0] data_in, in_phase_data, quadrature_data, i_word, q_word;
  logic [7:0]  rd_val, exp_v;
  int          mismatches, n_tests, seed, i;
  ipd_exp_t    exp_q[$];
  event        rd_done;
  logic [6:0]  ofs[4]  = '{OFS_POWER, OFS_LOOP_CTRL, OFS_LOOP_CFG, OFS_DELAY_CELL};
  logic [7:0]  rstv[4] = '{RST_POWER, RST_LOOP_CTRL, RST_LOOP_CFG, RST_DELAY_CELL};
  logic [3:0]  offs[6] = '{4'h1, 4'h6, 4'he, 4'h7, 4'hf, 4'h9};
  logic [7:0]  pw[4]   = '{8'hc0, 8'h40, 8'h00, 8'h80};

  // Short lock count keeps the run brief
  ipd_top #(.LOCK_CYCLES(4), .TIMEOUT(16), .DW(16)) u_ipd_top (
    .ref_clk(ref_clk), .rst(rst), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .forwarded_data_clock(fwd_clk), .data_in(data_in), .in_phase_data(in_phase_data),
    .quadrature_data(quadrature_data), .dac_out_en(dac_out_en),
    .phase_offset(phase_offset), .dcc_en(dcc_en));

  ipd_host_model u_ipd_host_model (
    .run(host_run), .i_word(i_word), .q_word(q_word),
    .forwarded_data_clock(fwd_clk), .data_in(data_in));

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Counts: %0d checks, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // Serial clock held five ref cycles per phase so the synchroniser sees every edge
  task automatic pulse(input logic b, output logic s);
    tb_sdio = b;
    spi_clk = 1'b0;
    tick(5);
    s = sdio_out;
    spi_clk = 1'b1;
    tick(5);
  endtask : pulse

  task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    logic        s;
    int          k;
    f = {r, a, d};
    spi_cs_n = 1'b0;
    tick(3);
    for (k = 15; k >= 8; k--)
      pulse(f[k], s);
    for (k = 0; k < 12 && r && sdio_oe !== 1'b1; k++)
      tick(1);
    if (r && sdio_oe !== 1'b1)
    begin
      mismatches++;
      report_and_stop;
    end
    else
    begin
      for (k = 7; k >= 0; k--)
      begin
        pulse(f[k] ^ r, s);
        rd_val[k] = s;
      end
      spi_cs_n = 1'b1;
      tick(5);
      chk("sdio_oe", 16'h0000, {15'h0, sdio_oe});
    end
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string nm);
    exp_q.push_back(ipd_exp_t'{nm, e});
    xfer(1'b1, a, 8'h00);
    -> rd_done;
  endtask : rd

  initial
  forever
  begin
    @(rd_done);
    chk(exp_q[0].name, {8'h00, exp_q[0].val}, {8'h00, rd_val});
    void'(exp_q.pop_front());
  end

  initial
  begin
    seed = 45861;
    mismatches = 0;
    n_tests = 0;
    rst = 1'b1;
    spi_clk = 1'b1;
    spi_cs_n = 1'b1;
    tb_sdio = 1'b0;
    host_run = 1'b0;
    i_word = 16'h0000;
    q_word = 16'h0000;
    tick(10);
    rst = 1'b0;
    tick(3);
    chk("dac_out_en", 16'h0001, {15'h0, dac_out_en});
    chk("dcc_en", 16'h0000, {15'h0, dcc_en});
    for (i = 0; i < 4; i++)
      rd(ofs[i], rstv[i], "reset_value");
    rd(OFS_LOOP_STAT, 8'h00, "status_no_clock");
    for (i = 0; i < 4; i++)
    begin
      exp_v = 8'($random(seed));
      wr(ofs[i], exp_v);
      rd(ofs[i], exp_v, "read_back");
      wr(ofs[i], 8'h00);
    end
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      wr(OFS_POWER, pw[i]);
      chk("dac_out_en", {15'h0, i > 1}, {15'h0, dac_out_en});
    end
    wr(OFS_POWER, 8'h00);
    $display("test mute done");
    host_run = 1'b1;
    tick(40);
    rd(OFS_LOOP_STAT, 8'h04, "status_clock_only");
    wr(OFS_DELAY_CELL, 8'hfe);
    wr(OFS_LOOP_CFG, 8'h86);
    wr(OFS_LOOP_CTRL, 8'hc0);
    chk("dcc_en", 16'h0001, {15'h0, dcc_en});
    chk("phase_offset", 16'h0000, {12'h0, phase_offset});
    tick(10);
    rd(OFS_LOOP_STAT, 8'h85, "status_locked");
    for (i = 0; i < 6; i++)
    begin
      wr(OFS_LOOP_CTRL, 8'hc0 | offs[i]);
      chk("phase_offset", {12'h0, offs[i]}, {12'h0, phase_offset});
      exp_v = 8'h85 | (offs[i][2:0] == 3'h7 ? 8'h40 : 8'h00)
                    | (offs[i][2:0] == 3'h6 ? 8'h20 : 8'h00);
      rd(OFS_LOOP_STAT, exp_v, "status_warning");
    end
    wr(OFS_DELAY_CELL, 8'hff);
    rd(OFS_LOOP_STAT, 8'h95, "status_cell_warning");
    wr(OFS_DELAY_CELL, 8'hfe);
    wr(OFS_LOOP_CFG, 8'h06);
    wr(OFS_LOOP_CTRL, 8'hc0);
    wr(OFS_LOOP_STAT, 8'h00);
    rd(OFS_LOOP_STAT, 8'h85, "status_read_only");
    wr(7'h30, 8'h5a);
    rd(7'h30, 8'h00, "unmapped");
    for (i = 0; i < 4; i++)
    begin
      i_word = 16'($random(seed));
      q_word = 16'($random(seed));
      tick(4);
      chk("in_phase_data", i_word, in_phase_data);
      chk("quadrature_data", q_word, quadrature_data);
    end
    $display("test loop done");
    // Clock vanishes during the data phase; the read must still show the locked view
    fork
      rd(OFS_LOOP_STAT, 8'h85, "status_snapshot");
      begin
        tick(90);
        host_run = 1'b0;
      end
    join
    tick(40);
    rd(OFS_LOOP_STAT, 8'h00, "status_clock_lost");
    wr(OFS_POWER, 8'hc0);
    chk("dac_out_en", 16'h0000, {15'h0, dac_out_en});
    host_run = 1'b1;
    tick(40);
    wr(OFS_POWER, 8'h00);
    chk("dac_out_en", 16'h0001, {15'h0, dac_out_en});
    rd(OFS_LOOP_STAT, 8'h85, "status_relocked");
    wr(OFS_LOOP_CTRL, 8'h00);
    rd(OFS_LOOP_STAT, 8'h04, "status_loop_off");
    $display("test clock loss done");
    // Reset again in mid-run with the forwarded clock still toggling
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    tick(3);
    chk("dcc_en", 16'h0000, {15'h0, dcc_en});
    chk("dac_out_en", 16'h0001, {15'h0, dac_out_en});
    rd(OFS_LOOP_CTRL, RST_LOOP_CTRL, "ctrl_after_reset");
    rd(OFS_LOOP_STAT, 8'h04, "status_after_reset");
    $display("test mid reset done");
    report_and_stop;
  end
endmodule : ipd_top_tb_top
